/* logic/adc_delayed_ext_trigger_sweep.sv */
// sequencer for the delayed external-trigger two-phase single sweep
// Functional notes
// - trigger falling edge starts a sweep; only channel 0 converts first.
// - channel 1 waits for a second trigger falling edge.
// - second edge during channel 0 samples channel 1; rest follows at once.
// - edges during the second phase are ignored until sweep end.
// - an edge after sweep completion starts a fresh channel 0 conversion.
// - one interrupt pulse per completed sweep, not per channel.
// - sweep covers channels 0..1, 0..3, 0..5 or 0..7 by scan width.
// - each channel result lands in its own result register.
// - trigger edges sampled on the converter clock; source spaces them.
// - 10-bit result in bits 0..9, 8-bit result in bits 0..7.
// - sample-and-hold conversion takes 28 or 33 converter clocks.
`timescale 1ns/1ps
module adc_delayed_ext_trigger_sweep
  import adc_dly_pkg::*;
(
  input wire logic sys_clk, // converter operation clock, 20 MHz
  input wire logic reset, // async, active high
  input wire logic ext_trigger_n, // external trigger pin, active low
  input wire logic trigger_enable, // must be 0 in this mode
  input wire logic alt_trigger_sel, // must be 1 in this mode
  input wire logic timer_trig_sel_a, // must be 0 in this mode
  input wire logic timer_trig_sel_b, // must be 0 in this mode
  input wire logic conv_start_bit, // software view of start bit; 0 halts
  input wire logic scan_width_hi, // scan width code bit 1
  input wire logic scan_width_lo, // scan width code bit 0
  input wire logic input_group_hi, // input group select bit 1
  input wire logic input_group_lo, // input group select bit 0
  input wire logic ten_bit_res, // 1 = 10-bit result, 0 = 8-bit
  input wire logic sample_hold_en, // sample-and-hold option
  input wire logic ladder_connect, // reference ladder connected
  input wire logic [RES_W-1:0] sar_code, // raw code from the comparator array
  output logic [NUM_CH*RES_W-1:0] chan_result_reg, // per-channel results
  output logic conv_irq, // one-cycle pulse at sweep completion
  output logic conv_busy, // sweep in progress
  output logic [2:0] conv_channel, // channel being converted
  output logic [1:0] active_group, // input group latched for this sweep
  output logic sample_ch1, // one-cycle pulse: sample channel 1 now
  output logic pending_second // second-phase request held
);
  conv_core_if cc ();

  // one conversion timer serves all channels; from channel 1 on, channels run back to back
  conv_timer u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .cc(cc.core)
  );

  // trigger pin synchroniser: three stages, change accepted when two and three agree
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  logic trig_level;
  logic next_trig_level;
  logic trig_fall;
  logic next_s1;
  logic next_s2;
  logic next_s3;

  always_comb begin
    // stage one may be metastable, so only stage two ever reads it
    next_s1 = ext_trigger_n;
    next_s2 = trig_s1;
    next_s3 = trig_s2;
    next_trig_level = trig_level;
    if (trig_s2 == trig_s3) begin
      next_trig_level = trig_s3;
    end
    trig_fall = trig_level && !next_trig_level;
  end

  // preset high to match the idle pin, so leaving reset makes no false edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_s3 <= 1'b1;
      trig_level <= 1'b1;
    end else begin
      trig_s1 <= next_s1;
      trig_s2 <= next_s2;
      trig_s3 <= next_s3;
      trig_level <= next_trig_level;
    end
  end

  // pin-trigger selection; other trigger settings leave the sequencer idle
  logic pin_trig_sel;
  logic mode_ok;
  logic [2:0] last_ch;
  always_comb begin
    pin_trig_sel = !trigger_enable && alt_trigger_sel && !timer_trig_sel_a
                   && !timer_trig_sel_b;
    // a cut ladder would give meaningless codes, so the sweep stays parked
    mode_ok = pin_trig_sel && ladder_connect;
    // the scan width is copied into last_q at the first edge
    unique case ({scan_width_hi, scan_width_lo})
      SCAN_2CH: last_ch = LAST_CH_2;
      SCAN_4CH: last_ch = LAST_CH_4;
      SCAN_6CH: last_ch = LAST_CH_6;
      SCAN_8CH: last_ch = LAST_CH_8;
    endcase
  end

  // sequencer state: idle, channel 0, waiting for edge two, remaining channels
  seq_state_t state;
  seq_state_t next_state;
  logic [2:0] chan;
  logic [2:0] next_chan;
  logic [2:0] last_q;
  logic [2:0] next_last_q;
  logic pend;
  logic next_pend;
  logic irq_q;
  logic next_irq;
  logic samp_q;
  logic next_samp;
  logic busy_q;
  logic next_busy;
  logic [1:0] grp_q;
  logic [1:0] next_grp;
  logic launch;
  logic halt;

  // halting by clearing the start bit: software keeps it high while armed
  assign halt = !conv_start_bit || !mode_ok;

  always_comb begin
    next_state = state;
    next_chan = chan;
    next_last_q = last_q;
    next_pend = pend;
    next_irq = 1'b0;
    next_samp = 1'b0;
    next_grp = grp_q;
    launch = 1'b0;
    if (halt) begin
      next_state = SEQ_IDLE;
      next_pend = 1'b0;
      next_chan = 3'h0;
    end else begin
      unique case (state)
        SEQ_IDLE: begin
          if (trig_fall) begin
            next_state = SEQ_FIRST;
            next_chan = 3'h0;
            next_last_q = last_ch;
            next_grp = {input_group_hi, input_group_lo};
            launch = 1'b1;
          end
        end
        SEQ_FIRST: begin
          if (trig_fall && !pend) begin
            next_pend = 1'b1;
            next_samp = 1'b1;
          end
          // an edge in the done cycle itself still counts as the second edge
          if (cc.done) begin
            if (pend || (trig_fall && !pend)) begin
              next_state = SEQ_REST;
              next_chan = 3'h1;
              next_pend = 1'b0;
              launch = 1'b1;
            end else begin
              next_state = SEQ_HOLD;
            end
          end
        end
        SEQ_HOLD: begin
          // no timeout: the sweep waits as long as the source needs
          if (trig_fall) begin
            next_state = SEQ_REST;
            next_chan = 3'h1;
            next_samp = 1'b1;
            launch = 1'b1;
          end
        end
        SEQ_REST: begin
          // trigger edges here are dropped on purpose
          // the source must wait for the interrupt before its next first edge
          if (cc.done) begin
            if (chan == last_q) begin
              next_state = SEQ_IDLE;
              next_irq = 1'b1;
              next_chan = 3'h0;
            end else begin
              next_chan = chan + 3'h1;
              launch = 1'b1;
            end
          end
        end
      endcase
    end
    next_busy = (next_state != SEQ_IDLE);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= SEQ_IDLE;
      chan <= 3'h0;
      last_q <= LAST_CH_2;
      pend <= 1'b0;
      irq_q <= 1'b0;
      samp_q <= 1'b0;
      busy_q <= 1'b0;
      grp_q <= GROUP_PRIMARY;
    end else begin
      state <= next_state;
      chan <= next_chan;
      last_q <= next_last_q;
      pend <= next_pend;
      irq_q <= next_irq;
      samp_q <= next_samp;
      busy_q <= next_busy;
      grp_q <= next_grp;
    end
  end

  // per-sweep settings: frozen at the first edge so a late software change
  // cannot mix result widths or conversion lengths inside one sweep
  logic res_q;
  logic next_res;
  logic sh_q;
  logic next_sh;
  logic sweep_ten_bit;
  logic sweep_sh_en;

  always_comb begin
    next_res = res_q;
    next_sh = sh_q;
    if (state == SEQ_IDLE) begin
      next_res = ten_bit_res;
      next_sh = sample_hold_en;
    end
    // while idle the live bits pass straight through for the first launch
    sweep_ten_bit = (state == SEQ_IDLE) ? ten_bit_res : res_q;
    sweep_sh_en = (state == SEQ_IDLE) ? sample_hold_en : sh_q;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      res_q <= 1'b0;
      sh_q <= 1'b0;
    end else begin
      res_q <= next_res;
      sh_q <= next_sh;
    end
  end

  // timer control; resolution and hold option come from the per-sweep copy
  assign cc.start = launch;
  assign cc.abort = halt;
  assign cc.ten_bit = sweep_ten_bit;
  assign cc.sh_en = sweep_sh_en;

  // result storage, one register per channel
  logic [RES_W-1:0] result [NUM_CH];
  logic [RES_W-1:0] next_result [NUM_CH];
  logic [RES_W-1:0] masked_code;

  always_comb begin
    // 8-bit mode keeps the upper two bits clear so readers see a clean value
    masked_code = sweep_ten_bit ? sar_code : {2'h0, sar_code[7:0]};
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_res
      // a halted conversion leaves the previous result in place
      always_comb begin
        next_result[gi] = result[gi];
        if (cc.done && !halt && (chan == 3'(gi))) begin
          next_result[gi] = masked_code;
        end
      end
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          result[gi] <= RESULT_RESET;
        end else begin
          result[gi] <= next_result[gi];
        end
      end
      assign chan_result_reg[gi*RES_W +: RES_W] = result[gi];
    end
  endgenerate

  assign conv_irq = irq_q;
  assign conv_busy = busy_q;
  assign conv_channel = chan;
  assign active_group = grp_q;
  assign sample_ch1 = samp_q;
  assign pending_second = pend;
endmodule

/* inc/adc_dly_pkg.sv */
// constants and types for the delayed external-trigger sweep sequencer
package adc_dly_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned RES_W = 10;
  localparam int unsigned CNT_W = 6;
  // conversion lengths in converter clock cycles with sample-and-hold
  localparam logic [CNT_W-1:0] CONV_CYC_8BIT = 6'd28;
  localparam logic [CNT_W-1:0] CONV_CYC_10BIT = 6'd33;
  // conversion length without sample-and-hold (plain default)
  localparam logic [CNT_W-1:0] CONV_CYC_NOSH_8BIT = 6'd31;
  localparam logic [CNT_W-1:0] CONV_CYC_NOSH_10BIT = 6'd36;
  // scan width codes
  localparam logic [1:0] SCAN_2CH = 2'h0;
  localparam logic [1:0] SCAN_4CH = 2'h1;
  localparam logic [1:0] SCAN_6CH = 2'h2;
  localparam logic [1:0] SCAN_8CH = 2'h3;
  localparam logic [2:0] LAST_CH_2 = 3'h1;
  localparam logic [2:0] LAST_CH_4 = 3'h3;
  localparam logic [2:0] LAST_CH_6 = 3'h5;
  localparam logic [2:0] LAST_CH_8 = 3'h7;
  localparam logic [1:0] GROUP_PRIMARY = 2'h0;
  localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_HOLD, SEQ_REST} seq_state_t;
endpackage

/* inc/conv_core_if.sv */
// handshake between sequencer and conversion timer
`timescale 1ns/1ps
interface conv_core_if;
  import adc_dly_pkg::*;
  logic start;
  logic ten_bit;
  logic sh_en;
  logic abort;
  logic busy;
  logic done;
  modport seq (output start, output ten_bit, output sh_en, output abort,
               input busy, input done);
  modport core (input start, input ten_bit, input sh_en, input abort,
                output busy, output done);
endinterface

/* logic/conv_timer.sv */
// per-channel conversion timer: counts out one conversion
`timescale 1ns/1ps
module conv_timer
  import adc_dly_pkg::*;
(
  input wire logic sys_clk, // converter operation clock
  input wire logic reset, // async, active high
  conv_core_if.core cc // start/abort in, busy/done out
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic busy_q;
  logic next_busy;
  logic done_q;
  logic next_done;
  logic [CNT_W-1:0] length;

  always_comb begin
    if (cc.sh_en) begin
      length = cc.ten_bit ? CONV_CYC_10BIT : CONV_CYC_8BIT;
    end else begin
      length = cc.ten_bit ? CONV_CYC_NOSH_10BIT : CONV_CYC_NOSH_8BIT;
    end
    next_count = count;
    next_busy = busy_q;
    next_done = 1'b0;
    if (cc.abort) begin
      next_busy = 1'b0;
      next_count = '0;
    end else if (cc.start && !busy_q) begin
      next_busy = 1'b1;
      next_count = length - 6'd1;
    end else if (busy_q) begin
      if (count == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 6'd1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      count <= next_count;
      busy_q <= next_busy;
      done_q <= next_done;
    end
  end

  assign cc.busy = busy_q;
  assign cc.done = done_q;
endmodule

/* tb/trig_src.sv */
// external trigger source model
`timescale 1ns/1ps
module trig_src (
  input wire logic sys_clk, // clock
  input wire logic fire, // request one edge
  output logic ext_trigger_n // trigger pin
);
  logic [2:0] low_left = 3'h0;
  // low for 4 clocks so the synchroniser sees it; edges stay clocks apart
  always @(posedge sys_clk) begin
    if (fire) begin
      low_left <= 3'h4;
    end else if (low_left != 3'h0) begin
      low_left <= low_left - 3'h1;
    end
  end
  // pulled up between edges
  assign ext_trigger_n = (low_left == 3'h0);
endmodule

/* tb/adc_sweep_chk.sv */
// port assertions for the sweep sequencer
`timescale 1ns/1ps
module adc_sweep_chk (
  input wire logic sys_clk, // clock
  input wire logic reset, // reset
  input wire logic trigger_enable, // mode bit
  input wire logic conv_start_bit, // arm
  input wire logic scan_width_hi, // scan
  input wire logic scan_width_lo, // scan
  input wire logic ten_bit_res, // res
  input wire logic sample_hold_en, // s&h
  input wire logic conv_irq, // done
  input wire logic conv_busy, // busy
  input wire logic [2:0] conv_channel, // channel
  input wire logic sample_ch1, // ch1 sample
  input wire logic pending_second // held edge
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic seen2;
  logic [2:0] prev_ch;
  logic [6:0] hold;
  // hold saturates so a long wait for the second edge cannot wrap
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seen2 <= 1'b0;
      prev_ch <= 3'h0;
      hold <= 7'h00;
    end else begin
      seen2 <= conv_busy & (seen2 | sample_ch1);
      prev_ch <= conv_channel;
      hold <= (conv_channel != prev_ch) ? 7'h01 : hold + {6'h00, hold != 7'h7f};
    end
  end
  irq_one_pulse_a: assert property (conv_irq |=> !conv_irq)
    else $error("irq too long");
  irq_ends_sweep_a: assert property (conv_irq |-> $past(conv_busy))
    else $error("irq without sweep");
  halt_idle_a: assert property (!conv_start_bit |=> !conv_busy && !pending_second)
    else $error("busy while halted");
  mode_idle_a: assert property (trigger_enable |=> !conv_busy)
    else $error("busy in wrong mode");
  ch1_waits_a: assert property (
    conv_busy && conv_channel != 3'h0 |-> seen2 || sample_ch1)
    else $error("second phase without edge");
  one_second_a: assert property (sample_ch1 |-> conv_busy && !seen2)
    else $error("extra second edge taken");
  scan_limit_a: assert property (
    conv_busy |-> conv_channel <= {scan_width_hi, scan_width_lo, 1'b1})
    else $error("channel beyond scan");
  step_one_a: assert property (
    conv_busy && $past(conv_busy) && conv_channel != prev_ch && conv_channel != 3'h0
    |-> conv_channel == prev_ch + 3'h1) else $error("channel skipped");
  conv_time_a: assert property (
    conv_busy && conv_channel != prev_ch && conv_channel > 3'h1 && sample_hold_en
    |-> hold - (ten_bit_res ? 7'h21 : 7'h1c) <= 7'h01) else $error("bad length");
endmodule
bind adc_delayed_ext_trigger_sweep adc_sweep_chk u_chk (.sys_clk(sys_clk), .reset(reset),
  .trigger_enable(trigger_enable), .conv_start_bit(conv_start_bit),
  .scan_width_hi(scan_width_hi), .scan_width_lo(scan_width_lo), .ten_bit_res(ten_bit_res),
  .sample_hold_en(sample_hold_en), .conv_irq(conv_irq), .conv_busy(conv_busy),
  .conv_channel(conv_channel), .sample_ch1(sample_ch1), .pending_second(pending_second));

/* tb/adc_delayed_ext_trigger_sweep_tb.sv */
// self-checking bench for the delayed-trigger sweep sequencer
`timescale 1ns/1ps
module adc_delayed_ext_trigger_sweep_tb;
  import adc_dly_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic fire = 1'b0;
  logic trigger_enable = 1'b0;
  logic conv_start_bit = 1'b1; // held as an arm level, never pulsed to one
  logic ladder = 1'b1;
  logic ten_bit_res = 1'b1;
  logic [1:0] scan = 2'h0;
  logic [1:0] grp = 2'h0;
  logic [6:0] base = 7'h00;
  logic [9:0] sar_code = 10'h000;
  logic ext_trigger_n, conv_irq, conv_busy, sample_ch1, pending_second;
  logic [2:0] conv_channel;
  logic [1:0] active_group;
  logic [NUM_CH*RES_W-1:0] chan_result_reg;
  logic [9:0] exp_res [8];
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int irq_n = 0;
  int samp_n = 0;
  int s0;
  int n0;
  always #25 sys_clk = ~sys_clk;
  // the code carries the channel so a misplaced result shows
  always @(posedge sys_clk) sar_code <= {conv_channel, base};
  always @(negedge sys_clk) irq_n += int'(conv_irq === 1'b1);
  always @(negedge sys_clk) samp_n += int'(sample_ch1 === 1'b1);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done;
    end
  end
  trig_src u_trig_src (.sys_clk(sys_clk), .fire(fire), .ext_trigger_n(ext_trigger_n));
  adc_delayed_ext_trigger_sweep u_adc_delayed_ext_trigger_sweep (.sys_clk(sys_clk),
    .reset(reset), .ext_trigger_n(ext_trigger_n), .trigger_enable(trigger_enable),
    .alt_trigger_sel(1'b1), .timer_trig_sel_a(1'b0), .timer_trig_sel_b(1'b0),
    .conv_start_bit(conv_start_bit), .scan_width_hi(scan[1]), .scan_width_lo(scan[0]),
    .input_group_hi(grp[1]), .input_group_lo(grp[0]), .ten_bit_res(ten_bit_res),
    .sample_hold_en(1'b1), .ladder_connect(ladder), .sar_code(sar_code),
    .chan_result_reg(chan_result_reg), .conv_irq(conv_irq), .conv_busy(conv_busy),
    .conv_channel(conv_channel), .active_group(active_group), .sample_ch1(sample_ch1),
    .pending_second(pending_second));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic settle;
    @(negedge sys_clk);
  endtask
  task automatic trig;
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    tick(8);
  endtask
  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({9'h000, got}, {9'h000, exp});
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    while (conv_irq !== 1'b1 && k < 600) begin
      settle;
      k++;
    end
    chk_bit(k < 600, 1'b1);
  endtask
  task automatic test_done;
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    for (int c = 0; c < 8; c++) exp_res[c] = 10'h000;
    tick(8);
    reset <= 1'b0;
    tick(4);
    for (int i = 0; i < 4; i++) begin
      scan <= i[1:0];
      grp <= ~i[1:0];
      ten_bit_res <= ~i[0];
      base <= 7'h31 ^ {5'h00, i[1:0]};
      n0 = irq_n;
      s0 = samp_n;
      trig();
      settle;
      chk_bit(conv_busy, 1'b1);
      chk_val({7'h00, conv_channel}, 10'h000);
      chk_val({8'h00, active_group}, {8'h00, grp});
      if (i[0]) begin
        trig();
        settle;
        chk_bit(pending_second, 1'b1);
        if (i == 3) begin
          tick(50);
          trig();
        end
      end else begin
        tick(60);
        settle;
        chk_val({7'h00, conv_channel}, 10'h000);
        chk_bit(conv_busy, 1'b1);
        trig();
      end
      wait_irq();
      tick(3);
      chk_val(10'(irq_n - n0), 10'h001);
      chk_val(10'(samp_n - s0), 10'h001);
      chk_bit(conv_busy, 1'b0);
      for (int c = 0; c < 8; c++) begin
        if (c <= 2 * i + 1) exp_res[c] = {c[2:0], base} & (i[0] ? 10'h0ff : 10'h3ff);
        chk_val(chan_result_reg[c*RES_W +: RES_W], exp_res[c]);
      end
    end
    n0 = irq_n;
    trig();
    trig();
    conv_start_bit <= 1'b0;
    tick(2);
    chk_bit(conv_busy, 1'b0);
    chk_bit(pending_second, 1'b0);
    conv_start_bit <= 1'b1;
    tick(80);
    chk_val(10'(irq_n - n0), 10'h000);
    chk_val(chan_result_reg[RES_W-1:0], exp_res[0]);
    trigger_enable <= 1'b1;
    trig();
    chk_bit(conv_busy, 1'b0);
    trigger_enable <= 1'b0;
    ladder <= 1'b0;
    trig();
    chk_bit(conv_busy, 1'b0);
    ladder <= 1'b1;
    tick(2);
    trig();
    chk_bit(conv_busy, 1'b1);
    test_done;
  end
endmodule
